// file: pkg/okc_pkg.sv
// package: configuration page layout, key classes, register offsets
// What this block does
// - two-bit key class: 00 DES/2DES, 01 3DES, 10 AES-128, 11 AES-192/256
// - bits 27:26 govern keys in pages 7 and 8
// - bits 25:24 govern keys in pages 5 and 6
// - bits 23:22 govern keys in pages 3 and 4
// - bits 21:20 govern keys in pages 1 and 2
// - bit 30 reads 1 once the page is programmed, else 0
// - bits 29 and 28 always read as zero
// - programmed flag mirrored at bit 7 of the otp control register
// - implemented bits program once; top bit reserved, loaded from otp and never modified by writes
// - session-key enable limits stored key one to key-encrypting use
// - with source lock, highest set locked-source bit forces key source
// - nine write-lock bits: bit 0 permanently blocks programming of page 0, bits 1 to 8 only drive o_page_write_lock
// - software key off and source 0000 sets key failure, blocks start
package okc_pkg;
  localparam logic [3:0] ADDR_CONFIG  = 4'h0;
  localparam logic [3:0] ADDR_OTP_CTL = 4'h1;
  localparam logic [3:0] ADDR_KEY_SEL = 4'h2;
  localparam logic [3:0] ADDR_STATUS  = 4'h3;
  localparam int BIT_RESERVED   = 31;
  localparam int BIT_PROGRAMMED = 30;
  localparam int BIT_MIRROR     = 7;
  localparam int BIT_SRC_LOCK   = 10;
  localparam int BIT_SESSION    = 19;
  localparam int BIT_SW_DIS     = 0;
  localparam logic [31:0] UNIMPL_MASK = 32'h3000_0000;
  localparam logic [3:0] SRC_SOFTWARE = 4'h0;
  localparam logic [3:0] SRC_KEY_ONE  = 4'h1;
  localparam logic [3:0] SRC_TOP      = 4'hf;
  localparam int PAGES = 9;

  typedef enum logic [1:0]
  {
    OKC_DES  = 2'h0,
    OKC_TDES = 2'h1,
    OKC_A128 = 2'h2,
    OKC_A256 = 2'h3
  } okc_class_t;

  typedef struct packed
  {
    logic          reserved;
    logic          programmed;
    logic [1:0]    unimpl;
    okc_class_t    pages_7_8_key_class;
    okc_class_t    pages_5_6_key_class;
    okc_class_t    pages_3_4_key_class;
    okc_class_t    pages_1_2_key_class;
    logic          session_key_only_enable;
    logic [7:0]    locked_key_source_field;
    logic          key_source_lock;
    logic [8:0]    page_write_lock;
    logic          software_key_disable;
  } okc_page_t;

  typedef struct packed
  {
    logic          start;
    okc_class_t    cipher_class;
    logic          key_wrap;
  } okc_req_t;
endpackage

// file: logic/okc_source_pick.sv
// module: locked key source priority decode
`timescale 1ns/100ps
module okc_source_pick
  import okc_pkg::*;
(
  input  wire logic [7:0] i_field,
  output logic      [3:0] o_source
);
  always_comb
  begin
    o_source = SRC_SOFTWARE;
    for (int b = 0; b < 8; b++)
    begin
      if (i_field[b])
      begin
        o_source = 4'(b + 1);
      end
    end
    if (i_field[7])
    begin
      o_source = SRC_TOP;
    end
  end
endmodule

// file: logic/okc_config_page.sv
// module: one-time configuration page and key-selection checks
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module okc_config_page
  import okc_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_otp_read_done,
  input  wire logic [31:0] i_otp_page,
  input  wire okc_req_t    i_req,
  output logic             o_start_ok,
  output logic             o_key_failure_flag,
  output logic [3:0]       o_key_source,
  output logic [8:0]       o_page_write_lock
);
  okc_page_t   page;
  okc_page_t   next_page;
  logic        loaded;
  logic        next_loaded;
  logic [3:0]  key_source_select;
  logic [3:0]  next_key_source_select;
  logic        fail;
  logic        next_fail;
  logic        start_ok;
  logic        next_start_ok;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [3:0]  locked_src;
  logic [3:0]  src;
  okc_class_t  pair_class;
  logic        bad;
  logic [31:0] prog_bits;

  okc_source_pick u_pick
  (
    .i_field  (page.locked_key_source_field),
    .o_source (locked_src)
  );

  // locked source overrides software selection
  assign src = page.key_source_lock ? locked_src
                                    : key_source_select;

  always_comb
  begin
    case (src)
      4'h1, 4'h2: pair_class = page.pages_1_2_key_class;
      4'h3, 4'h4: pair_class = page.pages_3_4_key_class;
      4'h5, 4'h6: pair_class = page.pages_5_6_key_class;
      4'h7, 4'h8: pair_class = page.pages_7_8_key_class;
      default:    pair_class = i_req.cipher_class;
    endcase
  end

  always_comb
  begin
    bad = 1'b0;
    if (!loaded)
    begin
      bad = 1'b1;
    end
    if (page.software_key_disable && src == SRC_SOFTWARE)
    begin
      bad = 1'b1;
    end
    if (src >= SRC_KEY_ONE && src <= 4'h8 && pair_class != i_req.cipher_class)
    begin
      bad = 1'b1;
    end
    if (page.session_key_only_enable && src == SRC_KEY_ONE && !i_req.key_wrap)
    begin
      bad = 1'b1;
    end
  end

  // program-once: only unprogrammed bits may go high, reserved/unimpl kept
  assign prog_bits = i_wdata & ~UNIMPL_MASK
                     & ~(32'h1 << BIT_RESERVED);

  always_comb
  begin
    next_page = page;
    next_loaded = loaded;
    next_key_source_select = key_source_select;
    next_fail = fail;
    next_start_ok = 1'b0;
    next_rdata = 32'h0;
    if (i_otp_read_done)
    begin
      next_page = okc_page_t'(i_otp_page & ~UNIMPL_MASK);
      next_loaded = 1'b1;
    end
    else if (i_wr && i_addr == ADDR_CONFIG && !page.page_write_lock[0])
    begin
      if (!page.programmed)
      begin
        next_page = okc_page_t'(32'(page) | prog_bits);
        next_page.programmed = 1'b1;
      end
    end
    if (i_wr && i_addr == ADDR_KEY_SEL)
    begin
      next_key_source_select = i_wdata[3:0];
    end
    if (i_wr && i_addr == ADDR_STATUS && i_wdata[0])
    begin
      next_fail = 1'b0;
    end
    if (i_req.start)
    begin
      if (bad)
      begin
        next_fail = 1'b1; // set wins over clear
      end
      else
      begin
        next_start_ok = 1'b1;
      end
    end
    if (i_rd)
    begin
      case (i_addr)
        ADDR_CONFIG:  next_rdata = 32'(page) & ~UNIMPL_MASK;
        ADDR_OTP_CTL: next_rdata = 32'(page.programmed)
                                   << BIT_MIRROR;
        ADDR_KEY_SEL: next_rdata = {28'h0, key_source_select};
        ADDR_STATUS:  next_rdata = {30'h0, loaded, fail};
        default:      next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      page <= okc_page_t'(32'h0);
      loaded <= 1'b0;
      key_source_select <= 4'h0;
      fail <= 1'b0;
      start_ok <= 1'b0;
      rdata <= 32'h0;
    end
    else
    begin
      page <= next_page;
      loaded <= next_loaded;
      key_source_select <= next_key_source_select;
      fail <= next_fail;
      start_ok <= next_start_ok;
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;
  assign o_start_ok = start_ok;
  assign o_key_failure_flag = fail;
  assign o_key_source = src;
  assign o_page_write_lock = page.page_write_lock;

  // forward-looking forms keep a short reset from feeding stale past values
  unimpl_zero_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_rd && i_addr == ADDR_CONFIG |=> o_rdata[29:28] == 2'h0)
    else $error("unimplemented bits read nonzero");
  mirror_flag_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_rd && i_addr == ADDR_OTP_CTL
    |=> o_rdata[BIT_MIRROR] == $past(page.programmed))
    else $error("mirror differs from programmed flag");
  once_only_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    page.programmed && !i_otp_read_done
    |=> page == $past(page))
    else $error("programmed page changed");
  reserved_keep_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    !i_otp_read_done |=> page.reserved == $past(page.reserved))
    else $error("reserved bit modified");
  program_mark_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_wr && i_addr == ADDR_CONFIG && !page.page_write_lock[0]
    && !i_otp_read_done |=> page.programmed)
    else $error("programmed flag not set by write");
  lock_keep_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_wr && i_addr == ADDR_CONFIG && page.page_write_lock[0]
    && !i_otp_read_done |=> page == $past(page))
    else $error("locked page was programmed");
  swkey_fail_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_req.start && page.software_key_disable && src == SRC_SOFTWARE
    |=> o_key_failure_flag && !o_start_ok)
    else $error("software key start not refused");
  flag_sticky_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    o_key_failure_flag && !(i_wr && i_addr == ADDR_STATUS && i_wdata[0])
    |=> o_key_failure_flag)
    else $error("failure flag dropped without clear");
  class_fail_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_req.start && loaded && src == 4'h7
    && page.pages_7_8_key_class != i_req.cipher_class
    |=> !o_start_ok && o_key_failure_flag)
    else $error("class mismatch started");
  pages56_class_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_req.start && loaded && src == 4'h6
    && page.pages_5_6_key_class != i_req.cipher_class
    |=> !o_start_ok && o_key_failure_flag)
    else $error("pages 5 6 class mismatch started");
  pages34_class_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_req.start && loaded && src == 4'h3
    && page.pages_3_4_key_class != i_req.cipher_class
    |=> !o_start_ok && o_key_failure_flag)
    else $error("pages 3 4 class mismatch started");
  pages12_class_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_req.start && loaded && src == 4'h2
    && page.pages_1_2_key_class != i_req.cipher_class
    |=> !o_start_ok && o_key_failure_flag)
    else $error("pages 1 2 class mismatch started");
  session_key_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_req.start && page.session_key_only_enable && src == SRC_KEY_ONE
    && !i_req.key_wrap |=> o_key_failure_flag)
    else $error("key one used outside wrap");
  lock_top_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    page.key_source_lock && page.locked_key_source_field[7]
    |-> o_key_source == SRC_TOP)
    else $error("locked source not forced");
  free_source_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    !page.key_source_lock |-> o_key_source == key_source_select)
    else $error("unlocked source not software choice");
  unloaded_a: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    i_req.start && !loaded |=> !o_start_ok && o_key_failure_flag)
    else $error("start before page latched");
endmodule

// file: tb/okc_far_model.sv
// far side model: otp read engine feeding the configuration page
`timescale 1ns/100ps
module okc_far_model
(
  input  wire logic        i_clock,
  input  wire logic        i_load,
  input  wire logic [31:0] i_value,
  output logic             o_otp_read_done,
  output logic      [31:0] o_otp_page
);
  // page lines only mean something in the done cycle, so they invert after
  always @(posedge i_clock)
  begin
    o_otp_read_done <= i_load;
    o_otp_page      <= i_load ? i_value : ~i_value;
  end
endmodule

// file: tb/okc_config_page_bench.sv
// bench: configuration page against a behavioural model
`timescale 1ns/100ps
`define CHK(a,b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module okc_config_page_bench;
  import okc_pkg::*;
  logic        i_clock, i_sys_rst, i_wr, i_rd, ld, done, ok, kf, hit;
  logic [3:0]  i_addr, src;
  logic [31:0] i_wdata, o_rdata, otp, val, bus, exp;
  logic [8:0]  wl;
  logic [7:0]  f;
  okc_req_t    i_req;
  int          failures, checks, seed, s, c;

  okc_far_model far_u (.i_clock(i_clock), .i_load(ld), .i_value(val),
    .o_otp_read_done(done), .o_otp_page(bus));
  okc_config_page dut_u (.i_clock, .i_sys_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_otp_read_done(done), .i_otp_page(bus), .i_req,
    .o_start_ok(ok), .o_key_failure_flag(kf), .o_key_source(src),
    .o_page_write_lock(wl));

  function automatic logic [1:0] pair(input logic [31:0] p, input int n);
    return p[20 + 2 * ((n - 1) / 2) +: 2];
  endfunction
  function automatic logic [3:0] lock(input logic [7:0] f);
    for (int k = 7; k >= 0; k--)
      if (f[k])
        return (k == 7) ? 4'hf : 4'(k + 1);
    return 4'h0;
  endfunction

  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
  endtask
  // a refused start leaves the sticky flag, so it is cleared every time
  task automatic go(input int cl, input logic w, input logic e);
    @(posedge i_clock);
    i_req <= '{1'b1, okc_class_t'(cl[1:0]), w};
    @(posedge i_clock);
    i_req.start <= 1'b0;
    #1;
    `CHK(ok, e)
    `CHK(kf, !e)
    wr(ADDR_STATUS, 32'h1);
  endtask
  task automatic load(input logic [31:0] p);
    @(posedge i_clock);
    ld  <= 1'b1;
    val <= p;
    @(posedge i_clock);
    ld <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  initial
  begin
    repeat (20000) @(posedge i_clock);
    failures++;
    conclude;
  end

  initial
  begin
    seed = 74;
    i_sys_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    i_req = '0;
    ld = 1'b0;
    val = 32'h0;
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    go(0, 1'b1, 1'b0);
    for (int n = 0; n < 3; n++)
    begin
      otp = $random(seed);
      otp[30] = n[0];
      otp[10] = 1'b0;
      otp[1] = 1'b0;
      load(otp);
      rd(ADDR_CONFIG);
      `CHK(o_rdata, otp & ~UNIMPL_MASK)
      rd(ADDR_OTP_CTL);
      `CHK(o_rdata[BIT_MIRROR], otp[BIT_PROGRAMMED])
      `CHK(wl, otp[9:1])
      for (s = 1; s <= 8; s++)
      begin
        wr(ADDR_KEY_SEL, 32'(s));
        `CHK(src, 4'(s))
        for (c = 0; c < 4; c++)
        begin
          hit = pair(otp, s) == 2'(c);
          go(c, 1'b1, hit);
        end
      end
      wr(ADDR_CONFIG, 32'hffff_ffff);
      rd(ADDR_CONFIG);
      exp = otp[30] ? otp : otp | 32'h4fff_ffff;
      `CHK(o_rdata, exp & ~UNIMPL_MASK)
    end
    for (int k = 0; k < 9; k++)
    begin
      // random lower bits under a known top bit exercise the priority; the ninth pass leaves every bit clear
      f = (8'($random(seed)) >> k) | (8'h80 >> k);
      load({13'h0, f, 1'b1, 10'h0});
      `CHK(src, lock(f))
    end
    load(32'h1);
    wr(ADDR_KEY_SEL, 32'h0);
    go(0, 1'b1, 1'b0);
    // a start in the clearing cycle must leave the flag set
    @(posedge i_clock);
    i_addr      <= ADDR_STATUS;
    i_wdata     <= 32'h1;
    i_wr        <= 1'b1;
    i_req.start <= 1'b1;
    @(posedge i_clock);
    i_wr        <= 1'b0;
    i_req.start <= 1'b0;
    #1;
    `CHK(kf, 1'b1)
    `CHK(ok, 1'b0)
    rd(ADDR_STATUS);
    `CHK(o_rdata, 32'h3)
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS);
    `CHK(o_rdata, 32'h2)
    load(32'h0);
    go(0, 1'b1, 1'b1);
    load(32'h8_0000);
    wr(ADDR_KEY_SEL, 32'h1);
    rd(ADDR_KEY_SEL);
    `CHK(o_rdata, 32'h1)
    go(0, 1'b0, 1'b0);
    go(0, 1'b1, 1'b1);
    load(32'h2);
    wr(ADDR_CONFIG, 32'h0ff0_0000);
    rd(ADDR_CONFIG);
    `CHK(o_rdata, 32'h2)
    `CHK(wl, 9'h1)
    conclude;
  end
endmodule
